// ### three_stage_pipeline_exception_status_tb.sv
// Self-checking bench of the pipeline control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; got_v = 32'(g); exp_v = 32'(e); if (got_v !== exp_v) \
  begin n_fail++; $display("BAD %0t got %h exp %h", $time, got_v, exp_v); end end
`define WT(c) begin n = 0; while (!(c) && n < 90) begin @(posedge clk); n++; end end
module three_stage_pipeline_exception_status_tb;
  import tspx_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, rd_go = 1'b0, rd_d = 1'b0;
  logic imem_req, imem_ack, dec_valid, ex_valid, ex_kill, d_we, evt_take, spr_we;
  logic br_taken, br_delay, ex_illegal, ex_divzero, fpu_exc, exc_en, irq_en, nm_brk, brk, irq;
  logic ex_busy;
  logic [1:0] lat;
  logic [2:0] spr_sel, d_req, d_abort, d_ack, d_err;
  logic [3:0] d_be;
  logic [4:0] fpu_flags, r;
  logic [31:0] imem_addr, imem_data, dec_insn, ex_insn, ex_pc, br_target, d_addr, d_wdata;
  logic [31:0] spr_wdata, spr_rdata, evt_ret_pc, v, got_v, exp_v;
  tspx_dacc_type ex_dacc;
  tspx_event_type evt_kind;
  int n_fail = 0, comparisons = 0, n = 0, cyc = 0;
  logic [31:0] q_rd[$];
  logic [2:0] q_ab[$];
  tspx_event_type q_ev[$];
  logic [31:0] dmap[3] = '{32'h00000103, 32'h80000012, 32'h40000020};
  logic [3:0] dbe[3] = '{4'h1, 4'h3, 4'hF};
  tspx_size_type dsz[3] = '{TSPX_SZ_BYTE, TSPX_SZ_HALF, TSPX_SZ_WORD};
  logic [4:0] ec[3] = '{5'h02, 5'h05, 5'h06};
  logic [2:0] evr[3] = '{3'h7, 3'h3, 3'h1};
  tspx_event_type eve[3] = '{TSPX_EV_NMBRK, TSPX_EV_BRK, TSPX_EV_IRQ};
  always #4 clk = ~clk;
  tspx_core u_dut (.clk(clk), .rst_n(rst_n), .imem_req(imem_req), .imem_addr(imem_addr),
    .imem_ack(imem_ack), .imem_data(imem_data), .imem_err(1'b0), .dec_valid(dec_valid),
    .dec_insn(dec_insn), .ex_valid(ex_valid), .ex_insn(ex_insn), .ex_pc(ex_pc), .ex_kill(ex_kill),
    .ex_busy(ex_busy), .br_taken(br_taken), .br_delay(br_delay), .br_target(br_target),
    .ex_illegal(ex_illegal), .ex_divzero(ex_divzero), .fpu_exc(fpu_exc), .fpu_flags(fpu_flags),
    .ex_dacc(ex_dacc), .d_req(d_req), .d_abort(d_abort), .d_addr(d_addr), .d_be(d_be),
    .d_we(d_we), .d_wdata(d_wdata), .d_ack(d_ack), .d_err(d_err), .exc_en(exc_en),
    .brk_busy(1'b0), .irq_en(irq_en), .nm_brk(nm_brk), .brk(brk), .irq(irq), .spr_sel(spr_sel),
    .spr_we(spr_we), .spr_wdata(spr_wdata), .spr_rdata(spr_rdata), .evt_take(evt_take),
    .evt_kind(evt_kind), .evt_ret_pc(evt_ret_pc));
  tspx_mem_model u_mem (.clk(clk), .rst_n(rst_n), .lat(lat), .imem_req(imem_req),
    .imem_addr(imem_addr), .imem_ack(imem_ack), .imem_data(imem_data), .d_abort(d_abort),
    .d_ack(d_ack));
  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge clk)
  begin
    rd_d <= rd_go;
    cyc++;
    if (rd_d === 1'b1) `CHK(spr_rdata, q_rd.pop_front())
    if (evt_take === 1'b1) `CHK(evt_kind, q_ev.pop_front())
    if ((|d_abort) === 1'b1) `CHK(d_abort, q_ab.pop_front())
    if ((|d_req) === 1'b1) `CHK(d_req, 3'h7)
    if (imem_ack === 1'b1) `CHK(imem_addr[1:0], 2'h0)
    if (cyc > 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task rd(input logic [2:0] sel, input logic [31:0] e);
    @(posedge clk);
    spr_sel <= sel;
    rd_go <= 1'b1;
    q_rd.push_back(e);
    @(posedge clk);
    rd_go <= 1'b0;
  endtask
  task wr(input logic [2:0] sel, input logic [31:0] d);
    @(posedge clk);
    spr_sel <= sel;
    spr_wdata <= d;
    spr_we <= 1'b1;
    @(posedge clk);
    spr_we <= 1'b0;
  endtask
  task wfetch(input logic [31:0] a);
    `WT(imem_req === 1'b1 && imem_addr === a)
    `CHK(imem_addr, a)
  endtask
  task exc(input logic [2:0] src, input tspx_dacc_type da, input logic [31:0] exception_state_reg);
    lat <= 2'($urandom % 3);
    `WT(ex_valid === 1'b1)
    {ex_illegal, ex_divzero, fpu_exc} <= src;
    ex_dacc <= da;
    q_ev.push_back(TSPX_EV_EXC);
    `WT(evt_take === 1'b1)
    {ex_illegal, ex_divzero, fpu_exc} <= 3'h0;
    ex_dacc <= '0;
    wfetch(32'h00000020);
    rd(3'h5, exception_state_reg);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {br_taken, br_delay, ex_illegal, ex_divzero, fpu_exc, exc_en, irq_en, nm_brk, brk, irq} = '0;
    {spr_we, lat, spr_sel, fpu_flags, br_target, spr_wdata, ex_busy, d_err} = '0;
    ex_dacc = '0;
    v = $urandom(32'h22FDF10C);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    exc_en <= 1'b1;
    irq_en <= 1'b1;
    rd(3'h5, 32'h0);
    rd(3'h7, 32'h0);
    v = $urandom;
    wr(3'h7, v);
    fpu_flags <= 5'h0A;
    @(posedge clk);
    fpu_flags <= 5'h00;
    rd(3'h7, {27'h0, v[4:0] | 5'h0A});
    wr(3'h5, 32'hFFFFFFFF);
    rd(3'h5, 32'h0);
    $display("end of special registers");
    for (int k = 0; k < 3; k++)
      exc(3'(3'h4 >> k), '0, {27'h0, ec[k]});
    for (int k = 0; k < 4; k++)
    begin
      r = 5'($urandom);
      exc(3'h0, '{1'b1, k[0], k[1] ? TSPX_SZ_WORD : TSPX_SZ_HALF, r, 32'h101 + 32'(k[1]), v},
        {20'h0, k[1], k[0], r, 5'h01});
    end
    // Error from the owner interface gives a data bus exception
    v = $urandom;
    d_err <= 3'h7;
    q_ab.push_back(3'h5);
    exc(3'h0, '{1'b1, 1'b1, TSPX_SZ_WORD, 5'h0, 32'h80000000, v}, {27'h0, 5'h04});
    d_err <= 3'h0;
    rd(3'h3, 32'h80000000);
    $display("end of exceptions");
    for (int k = 0; k < 3; k++)
    begin
      v = $urandom;
      `WT(ex_valid === 1'b1)
      ex_dacc <= '{1'b1, 1'b1, dsz[k], 5'h3, dmap[k], v};
      q_ab.push_back(~(3'h1 << k));
      `WT((|d_req) === 1'b1)
      ex_dacc <= '0;
      `CHK(d_addr, dmap[k])
      `CHK(d_be, dbe[k])
      `CHK(d_we, 1'b1)
      `CHK(d_wdata, k == 0 ? {4{v[7:0]}} : k == 1 ? {2{v[15:0]}} : v)
      repeat (6) @(posedge clk);
    end
    $display("end of data accesses");
    for (int k = 0; k < 2; k++)
    begin
      `WT(ex_valid === 1'b1)
      br_taken <= 1'b1;
      br_delay <= k[0];
      br_target <= 32'h00000400 + 32'(k * 64);
      wfetch(32'h00000400 + 32'(k * 64));
      br_taken <= 1'b0;
    end
    $display("end of branches");
    for (int k = 0; k < 3; k++)
    begin
      `WT(ex_valid === 1'b1)
      {nm_brk, brk, irq} <= evr[k];
      q_ev.push_back(eve[k]);
      @(posedge clk);
      {nm_brk, brk, irq} <= 3'h0;
      `WT(evt_take === 1'b1)
      repeat (4) @(posedge clk);
    end
    $display("end of events");
    // Busy starts as an instruction enters execute; fetch must keep filling
    `WT(dec_valid === 1'b1)
    ex_busy <= 1'b1;
    @(posedge clk);
    v = ex_pc;
    n = 0;
    repeat (12)
    begin
      @(posedge clk);
      n += int'(imem_ack);
    end
    `CHK(ex_valid, 1'b1)
    `CHK(ex_pc, v)
    `CHK(n >= 2, 1'b1)
    ex_busy <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(ex_valid, 1'b1)
    @(posedge clk);
    `CHK(ex_valid, 1'b1)
    $display("end of stall");
    `CHK(q_ev.size() + q_rd.size() + q_ab.size(), 0)
    summarize();
  end
endmodule // three_stage_pipeline_exception_status_tb
`default_nettype wire

// ### tspx_core.sv
// Three-stage pipeline control with exception and float status
`include "tspx_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tspx_core #(
  parameter int PF_DEPTH = 4,
  parameter bit UNALIGN_EXC = 1'b1,
  parameter logic [2:0] IF_PRESENT = 3'h7,
  parameter logic [2:0][31:0] MAP_BASE = {32'h40000000, 32'h80000000, 32'h00000000},
  parameter logic [2:0][31:0] MAP_MASK = {32'hC0000000, 32'h80000000, 32'hC0000000}
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic imem_req,
  output logic [31:0] imem_addr,
  input wire logic imem_ack,
  input wire logic [31:0] imem_data,
  input wire logic imem_err,
  output logic dec_valid,
  output logic [31:0] dec_insn,
  output logic ex_valid,
  output logic [31:0] ex_insn,
  output logic [31:0] ex_pc,
  output logic ex_kill,
  input wire logic ex_busy,
  input wire logic br_taken,
  input wire logic br_delay,
  input wire logic [31:0] br_target,
  input wire logic ex_illegal,
  input wire logic ex_divzero,
  input wire logic fpu_exc,
  input wire logic [4:0] fpu_flags,
  input wire tspx_pkg::tspx_dacc_type ex_dacc,
  output logic [2:0] d_req,
  output logic [2:0] d_abort,
  output logic [31:0] d_addr,
  output logic [3:0] d_be,
  output logic d_we,
  output logic [31:0] d_wdata,
  input wire logic [2:0] d_ack,
  input wire logic [2:0] d_err,
  input wire logic exc_en,
  input wire logic brk_busy,
  input wire logic irq_en,
  input wire logic nm_brk,
  input wire logic brk,
  input wire logic irq,
  input wire logic [2:0] spr_sel,
  input wire logic spr_we,
  input wire logic [31:0] spr_wdata,
  output logic [31:0] spr_rdata,
  output logic evt_take,
  output tspx_pkg::tspx_event_type evt_kind,
  output logic [31:0] evt_ret_pc
);
  import tspx_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic rs1_r;
  logic rs2_r;
  wire rst_sync_n = rs2_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end
    else
    begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end

  // Big-endian lanes: byte offset 0 is the most significant byte
  function automatic logic [3:0] lane_of(tspx_size_type sz, logic [1:0] off);
    unique case (sz)
      TSPX_SZ_WORD: lane_of = 4'hF;
      TSPX_SZ_HALF: lane_of = off[1] ? 4'h3 : 4'hC;
      default: lane_of = 4'h8 >> off;
    endcase
  endfunction

  // ****************************************
  // Pipeline state
  // ****************************************
  tspx_fetch_type fs_r;
  logic [31:0] pc_r;
  logic [31:0] req_addr_r;
  logic drop_r;
  logic dec_valid_r;
  logic [31:0] dec_insn_r;
  logic [31:0] dec_pc_r;
  logic dec_ierr_r;
  logic ex_valid_r;
  logic [31:0] ex_insn_r;
  logic [31:0] ex_pc_r;
  logic ex_ierr_r;
  logic pf_in_ready;
  logic pf_out_valid;
  logic [64:0] pf_out_data;
  logic dpend_r;
  logic [2:0] d_req_r;
  logic [31:0] d_addr_r;
  logic [3:0] d_be_r;
  logic d_we_r;
  logic [31:0] d_wdata_r;
  logic [2:0] owner;
  logic [4:0] cause_r;
  logic [6:0] detail_r;
  logic [31:0] ear_r;
  logic [4:0] fsr_r;
  logic [31:0] spr_rdata_r;
  logic evt_take_r;
  tspx_event_type evt_kind_r;
  logic [31:0] evt_ret_r;

  // ****************************************
  // Data access checks and speculative issue
  // ****************************************
  wire acc_on = ex_valid_r & ex_dacc.valid;
  wire mis_word = (ex_dacc.size == TSPX_SZ_WORD) & (ex_dacc.addr[1:0] != 2'h0);
  wire mis_half = (ex_dacc.size == TSPX_SZ_HALF) & ex_dacc.addr[0];
  wire mis = acc_on & UNALIGN_EXC & (mis_word | mis_half);
  // Owner is only known the cycle after the request pulse
  wire d_resolve = |d_req_r;
  wire d_res = dpend_r & ~d_resolve;
  wire d_hit = |(d_ack & owner);
  wire d_bad = |(d_err & owner) | (owner == 3'h0);
  wire dbus_fail = d_res & d_bad;
  wire dfin = d_res & (d_hit | d_bad);

  // ****************************************
  // Event selection
  // ****************************************
  wire exc_raw = (ex_valid_r & (ex_ierr_r | ex_illegal | ex_divzero | fpu_exc)) | mis | dbus_fail;
  wire evt_exc = exc_raw & exc_en & ~brk_busy;
  wire issue_now = acc_on & ~dpend_r & ~evt_exc & ~mis;
  wire stall = ex_busy | issue_now | (dpend_r & ~dfin);
  wire advance = ~stall;
  wire evt_nm = nm_brk & advance & ~evt_exc;
  wire evt_brk = brk & ~brk_busy & advance & ~evt_exc & ~nm_brk;
  wire evt_irq = irq & irq_en & ~brk_busy & advance & ~evt_exc & ~nm_brk & ~brk;
  wire evt_go = evt_exc | evt_nm | evt_brk | evt_irq;
  wire br_nd_go = ex_valid_r & br_taken & ~br_delay & advance & ~evt_go;
  wire br_dly_go = ex_valid_r & br_taken & br_delay & advance & ~evt_go;
  wire flush_all = evt_go | br_nd_go;
  wire redirect = flush_all | br_dly_go;
  wire [31:0] evt_vec = evt_exc ? `TSPX_VEC_EXC : (evt_irq ? `TSPX_VEC_IRQ : `TSPX_VEC_BRK);
  wire [31:0] new_pc = evt_go ? evt_vec : {br_target[31:2], 2'h0};
  wire tspx_event_type kind_now = evt_exc ? TSPX_EV_EXC : evt_nm ? TSPX_EV_NMBRK :
    evt_brk ? TSPX_EV_BRK : evt_irq ? TSPX_EV_IRQ : TSPX_EV_NONE;

  // ****************************************
  // Fetch and prefetch buffer
  // ****************************************
  wire f_issue = (fs_r == TSPX_FS_IDLE) & pf_in_ready & ~redirect;
  wire f_push = (fs_r == TSPX_FS_WAIT) & imem_ack & ~drop_r & ~redirect;
  wire pf_pop = advance & ~redirect & pf_out_valid;

  tspx_prefetch #(
    .W(65),
    .DEPTH(PF_DEPTH)
  ) u_prefetch (
    .clk(clk),
    .rst_n(rst_sync_n),
    .flush(redirect),
    .in_valid(f_push),
    .in_ready(pf_in_ready),
    .in_data({imem_err, req_addr_r, imem_data}),
    .out_valid(pf_out_valid),
    .out_ready(pf_pop),
    .out_data(pf_out_data)
  );

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      fs_r <= TSPX_FS_IDLE;
      pc_r <= 32'h00000000;
      req_addr_r <= 32'h00000000;
      drop_r <= 1'b0;
    end
    else
    begin
      unique case (fs_r)
        TSPX_FS_IDLE: fs_r <= f_issue ? TSPX_FS_WAIT : TSPX_FS_IDLE;
        TSPX_FS_WAIT: fs_r <= imem_ack ? TSPX_FS_IDLE : TSPX_FS_WAIT;
      endcase
      // Word left in flight at a redirect belongs to the old path
      drop_r <= (fs_r == TSPX_FS_WAIT) & ~imem_ack & (drop_r | redirect);
      if (f_issue)
        req_addr_r <= pc_r;
      if (redirect)
        pc_r <= new_pc;
      else if (f_issue)
        pc_r <= pc_r + `TSPX_FETCH_STEP;
    end
  end

  // ****************************************
  // Decode and execute stages
  // ****************************************
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      dec_valid_r <= 1'b0;
      dec_insn_r <= 32'h00000000;
      dec_pc_r <= 32'h00000000;
      dec_ierr_r <= 1'b0;
      ex_valid_r <= 1'b0;
      ex_insn_r <= 32'h00000000;
      ex_pc_r <= 32'h00000000;
      ex_ierr_r <= 1'b0;
    end
    else
    begin
      if (redirect)
        dec_valid_r <= 1'b0;
      else if (advance)
      begin
        dec_valid_r <= pf_out_valid;
        dec_ierr_r <= pf_out_data[64];
        dec_pc_r <= pf_out_data[63:32];
        dec_insn_r <= pf_out_data[31:0];
      end
      if (flush_all)
        ex_valid_r <= 1'b0;
      else if (advance)
      begin
        ex_valid_r <= dec_valid_r;
        ex_ierr_r <= dec_ierr_r;
        ex_pc_r <= dec_pc_r;
        ex_insn_r <= dec_insn_r;
      end
    end
  end

  // ****************************************
  // Data side: all interfaces at once
  // ****************************************
  tspx_route #(
    .PRESENT(IF_PRESENT),
    .BASE(MAP_BASE),
    .MASK(MAP_MASK)
  ) u_route (
    .clk(clk),
    .rst_n(rst_sync_n),
    .start(d_resolve),
    .addr(d_addr_r),
    .owner(owner),
    .abort(d_abort)
  );

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      dpend_r <= 1'b0;
      d_req_r <= 3'h0;
      d_addr_r <= 32'h00000000;
      d_be_r <= 4'h0;
      d_we_r <= 1'b0;
      d_wdata_r <= 32'h00000000;
    end
    else
    begin
      dpend_r <= issue_now | (dpend_r & ~dfin);
      d_req_r <= issue_now ? IF_PRESENT : 3'h0;
      if (issue_now)
      begin
        d_addr_r <= ex_dacc.addr;
        d_be_r <= lane_of(ex_dacc.size, ex_dacc.addr[1:0]);
        d_we_r <= ex_dacc.store;
        unique case (ex_dacc.size)
          TSPX_SZ_WORD: d_wdata_r <= ex_dacc.wdata;
          TSPX_SZ_HALF: d_wdata_r <= {2{ex_dacc.wdata[15:0]}};
          default: d_wdata_r <= {4{ex_dacc.wdata[7:0]}};
        endcase
      end
    end
  end

  // ****************************************
  // Exception status, address and float status
  // ****************************************
  wire fsr_wr = spr_we & (spr_sel == `TSPX_SEL_FSR);
  wire [4:0] cause_now = (ex_valid_r & ex_ierr_r) ? `TSPX_EC_IBUS :
    (ex_valid_r & ex_illegal) ? `TSPX_EC_ILLEGAL : mis ? `TSPX_EC_UNALIGN :
    dbus_fail ? `TSPX_EC_DBUS : (ex_valid_r & ex_divzero) ? `TSPX_EC_DIVZERO : `TSPX_EC_FPU;
  wire cause_unal = cause_now == `TSPX_EC_UNALIGN;
  wire [6:0] detail_now = cause_unal ? {mis_word, ex_dacc.store, ex_dacc.reg_idx} :
    `TSPX_DETAIL_RST;
  wire [31:0] ear_now = cause_unal ? ex_dacc.addr : (dbus_fail ? d_addr_r : 32'h00000000);

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cause_r <= `TSPX_EC_NONE;
      detail_r <= `TSPX_DETAIL_RST;
      ear_r <= 32'h00000000;
      fsr_r <= `TSPX_FSR_RST;
    end
    else
    begin
      // Software writes never reach cause or detail
      if (evt_exc)
      begin
        cause_r <= cause_now;
        detail_r <= detail_now;
        ear_r <= ear_now;
      end
      // Flag set wins over a software write in the same cycle
      fsr_r <= (fsr_wr ? spr_wdata[`TSPX_FSR_MSB:0] : fsr_r) | fpu_flags;
    end
  end

  // ****************************************
  // Special register read and event report
  // ****************************************
  wire [31:0] esr_word = {20'h00000, detail_r, cause_r};
  wire [31:0] rd_mux = (spr_sel == `TSPX_SEL_ESR) ? esr_word :
    (spr_sel == `TSPX_SEL_FSR) ? {27'h0000000, fsr_r} :
    (spr_sel == `TSPX_SEL_EAR) ? ear_r : 32'h00000000;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      spr_rdata_r <= 32'h00000000;
      evt_take_r <= 1'b0;
      evt_kind_r <= TSPX_EV_NONE;
      evt_ret_r <= 32'h00000000;
    end
    else
    begin
      spr_rdata_r <= rd_mux;
      evt_take_r <= evt_go;
      evt_kind_r <= kind_now;
      evt_ret_r <= evt_go ? dec_pc_r : evt_ret_r;
    end
  end

  assign imem_req = fs_r == TSPX_FS_WAIT;
  assign imem_addr = {req_addr_r[31:2], 2'h0};
  assign dec_valid = dec_valid_r;
  assign dec_insn = dec_insn_r;
  assign ex_valid = ex_valid_r;
  assign ex_insn = ex_insn_r;
  assign ex_pc = ex_pc_r;
  assign ex_kill = evt_exc;
  assign d_req = d_req_r;
  assign d_addr = d_addr_r;
  assign d_be = d_be_r;
  assign d_we = d_we_r;
  assign d_wdata = d_wdata_r;
  assign spr_rdata = spr_rdata_r;
  assign evt_take = evt_take_r;
  assign evt_kind = evt_kind_r;
  assign evt_ret_pc = evt_ret_r;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_issue;
    issue_now;
  endsequence
  sequence s_resolve;
    (d_req == IF_PRESENT) && (d_abort == 3'h0) ##1 (d_abort == (IF_PRESENT & ~owner));
  endsequence
  property p_spec_issue;
    @(posedge clk) disable iff (!rst_sync_n) s_issue |=> s_resolve;
  endproperty
  a_spec_issue: assert property (p_spec_issue) else $error("speculative issue wrong");
  property p_fetch_align;
    @(posedge clk) disable iff (!rst_sync_n) imem_req |-> imem_addr[1:0] == 2'h0;
  endproperty
  a_fetch_align: assert property (p_fetch_align) else $error("fetch unaligned");
  property p_unal_cause;
    @(posedge clk) disable iff (!rst_sync_n)
      evt_exc && mis && !(ex_ierr_r || ex_illegal) |=>
      cause_r == `TSPX_EC_UNALIGN && detail_r[4:0] == $past(ex_dacc.reg_idx);
  endproperty
  a_unal_cause: assert property (p_unal_cause) else $error("unaligned cause");
  property p_zero_detail;
    @(posedge clk) disable iff (!rst_sync_n) cause_r != `TSPX_EC_UNALIGN |-> detail_r == 7'h00;
  endproperty
  a_zero_detail: assert property (p_zero_detail) else $error("detail not zero");
  property p_fsr_sticky;
    @(posedge clk) disable iff (!rst_sync_n) |fpu_flags |=>
      (fsr_r & $past(fpu_flags)) == $past(fpu_flags);
  endproperty
  a_fsr_sticky: assert property (p_fsr_sticky) else $error("flag lost");
  property p_esr_ro;
    @(posedge clk) disable iff (!rst_sync_n) spr_we && !evt_exc |=> $stable(cause_r) && $stable(detail_r);
  endproperty
  a_esr_ro: assert property (p_esr_ro) else $error("status written");
  property p_stall;
    @(posedge clk) disable iff (!rst_sync_n) ex_busy && ex_valid_r && !evt_go |=> ex_valid_r && $stable(ex_pc_r);
  endproperty
  a_stall: assert property (p_stall) else $error("stall lost");
  property p_br_flush;
    @(posedge clk) disable iff (!rst_sync_n) br_nd_go |=> !dec_valid_r && !ex_valid_r ##1 !ex_valid_r;
  endproperty
  a_br_flush: assert property (p_br_flush) else $error("branch flush");
  property p_br_delay;
    @(posedge clk) disable iff (!rst_sync_n) br_dly_go && dec_valid_r |=>
      ex_valid_r && ex_pc_r == $past(dec_pc_r) && !dec_valid_r;
  endproperty
  a_br_delay: assert property (p_br_delay) else $error("delay slot lost");
  property p_prio;
    @(posedge clk) disable iff (!rst_sync_n) evt_go && nm_brk |=>
      evt_kind_r == TSPX_EV_EXC || evt_kind_r == TSPX_EV_NMBRK;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");
endmodule // tspx_core
`default_nettype wire

// ### tspx_map.svh
// Register fields, codes and vectors of the pipeline control block
`ifndef TSPX_MAP_SVH
`define TSPX_MAP_SVH
// ****************************************
// Special register select codes
// ****************************************
`define TSPX_SEL_EAR 3'h3
`define TSPX_SEL_ESR 3'h5
`define TSPX_SEL_FSR 3'h7
// ****************************************
// Field positions, bit 0 of a word is its LSB
// ****************************************
`define TSPX_CAUSE_LSB 0
`define TSPX_CAUSE_MSB 4
`define TSPX_DETAIL_LSB 5
`define TSPX_DETAIL_MSB 11
`define TSPX_FSR_MSB 4
// ****************************************
// Cause codes and reset values
// ****************************************
`define TSPX_EC_NONE 5'h00
`define TSPX_EC_UNALIGN 5'h01
`define TSPX_EC_ILLEGAL 5'h02
`define TSPX_EC_IBUS 5'h03
`define TSPX_EC_DBUS 5'h04
`define TSPX_EC_DIVZERO 5'h05
`define TSPX_EC_FPU 5'h06
`define TSPX_DETAIL_RST 7'h00
`define TSPX_FSR_RST 5'h00
// ****************************************
// Event vectors and fetch step
// ****************************************
`define TSPX_VEC_EXC 32'h00000020
`define TSPX_VEC_BRK 32'h00000018
`define TSPX_VEC_IRQ 32'h00000010
`define TSPX_FETCH_STEP 32'h00000004
`endif

// ### tspx_mem_model.sv
// Memory side model answering instruction fetches and data accesses
`timescale 1ns/10ps
`default_nettype none
module tspx_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] lat,
  input wire logic imem_req,
  input wire logic [31:0] imem_addr,
  output logic imem_ack,
  output logic [31:0] imem_data,
  input wire logic [2:0] d_abort,
  output logic [2:0] d_ack
);
  logic [1:0] cnt_r;
  logic done_r;
  logic [2:0] own_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {cnt_r, done_r, own_r, imem_ack, d_ack} <= '0;
      imem_data <= 32'h0;
    end
    else
    begin
      imem_ack <= 1'b0;
      d_ack <= 3'h0;
      // Released bus toggles every cycle between the inverse of the last word and the word
      imem_data <= ~imem_data;
      if (!imem_req)
        done_r <= 1'b0;
      else if (!done_r && cnt_r >= lat)
      begin
        // One whole 32-bit big-endian word per fetch
        imem_ack <= 1'b1;
        imem_data <= {imem_addr[31:2], 2'h0};
        done_r <= 1'b1;
        cnt_r <= 2'h0;
      end
      else if (!done_r)
        cnt_r <= cnt_r + 2'h1;
      // Only the interface whose map holds the address answers
      if (|d_abort)
        own_r <= ~d_abort;
      if (|own_r)
      begin
        d_ack <= own_r;
        own_r <= 3'h0;
      end
    end
  end
endmodule // tspx_mem_model
`default_nettype wire

// ### tspx_pkg.sv
// Types shared by the pipeline control block
package tspx_pkg;
  typedef enum logic [1:0] {TSPX_SZ_BYTE = 2'h0, TSPX_SZ_HALF = 2'h1,
    TSPX_SZ_WORD = 2'h2} tspx_size_type;
  typedef enum logic [1:0] {TSPX_FS_IDLE = 2'h1, TSPX_FS_WAIT = 2'h2} tspx_fetch_type;
  typedef enum logic [4:0] {TSPX_EV_NONE = 5'h00, TSPX_EV_EXC = 5'h01,
    TSPX_EV_NMBRK = 5'h02, TSPX_EV_BRK = 5'h04, TSPX_EV_IRQ = 5'h08,
    TSPX_EV_RESET = 5'h10} tspx_event_type;
  typedef struct packed {
    logic valid;
    logic store;
    tspx_size_type size;
    logic [4:0] reg_idx;
    logic [31:0] addr;
    logic [31:0] wdata;
  } tspx_dacc_type;
endpackage

// ### tspx_prefetch.sv
// Prefetch buffer between instruction fetch and decode
`timescale 1ns/10ps
`default_nettype none
module tspx_prefetch #(
  parameter int W = 65,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rp_r];
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else if (flush)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
endmodule // tspx_prefetch
`default_nettype wire

// ### tspx_route.sv
// Data interface owner resolution and abort of the losers
`timescale 1ns/10ps
`default_nettype none
module tspx_route #(
  parameter logic [2:0] PRESENT = 3'h7,
  parameter logic [2:0][31:0] BASE = '0,
  parameter logic [2:0][31:0] MASK = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [31:0] addr,
  output logic [2:0] owner,
  output logic [2:0] abort
);
  logic [2:0] hit;
  logic [2:0] owner_r;
  logic [2:0] abort_r;
  // Maps never overlap, so at most one hit
  for (genvar i = 0; i < 3; i++)
  begin : g_map
    assign hit[i] = PRESENT[i] & ((addr & MASK[i]) == BASE[i]);
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      owner_r <= 3'h0;
      abort_r <= 3'h0;
    end
    else
    begin
      owner_r <= start ? hit : owner_r;
      abort_r <= start ? (PRESENT & ~hit) : 3'h0;
    end
  end
  assign owner = owner_r;
  assign abort = abort_r;
endmodule // tspx_route
`default_nettype wire
